// *** motor_ctrl_status_algo_regs.sv ***
// Purpose: algorithm command word and power-monitor status registers
// Assumes: serial bus engine delivers single-cycle read/write strobes
// Notes: command bits are triggers, nothing of them is stored
`timescale 1ns/10ps
// Behaviour
// - status bits 31-16 give bus current, count/256 amperes, resets zero.
// - status bits 15-0 give input power, count/64 watts, resets zero.
// - writing one to bit 31 stores shadow registers to nonvolatile memory.
// - writing one to bit 30 reloads shadow registers from nonvolatile memory.
// - writing one to bit 29 clears all driver and controller faults.
// - writing one to bit 28 clears the lock-fault retry counters.
// - bits 27-20 carry unlock key; store without correct key is refused.
// - watchdog acknowledge returns to zero by itself after being set.
// - command word at E6h, write-only, zero after reset, bits 19-1 reserved.
// - status word at ECh, zero after reset.
module motor_ctrl_status_algo_regs #(
    parameter logic [7:0] UNLOCK_KEY = motor_regs_pkg::UNLOCK_KEY_DEFAULT
) (
    input wire logic I_MCLK,
    input wire logic I_RESET_N,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic [15:0] I_BUS_CURRENT,
    input wire logic [15:0] I_INPUT_POWER,
    output logic [31:0] O_RDATA,
    output logic O_RVALID,
    output logic O_NVM_STORE,
    output logic O_NVM_RECALL,
    output logic O_FAULT_CLEAR,
    output logic O_RETRY_CLEAR,
    output logic O_STORE_REFUSED,
    output logic O_HOST_WD_ACK
);
    motor_regs_pkg::cmd_pulses_t dec_pulses;
    motor_regs_pkg::cmd_pulses_t pulses_reg;
    motor_regs_pkg::cmd_pulses_t pulses_next;
    motor_regs_pkg::pwr_sample_t sample_reg;
    motor_regs_pkg::pwr_sample_t sample_next;
    logic wd_ack_reg;
    logic wd_ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic algo_wr;

    assign algo_wr = I_WR & (I_ADDR == motor_regs_pkg::ALGO_CMD_OFS);

    cmd_decode #(
        .UNLOCK_KEY(UNLOCK_KEY)
    ) u_decode (
        .i_wr(algo_wr),
        .i_data(I_WDATA),
        .o_pulses(dec_pulses)
    );

    always_comb begin
        pulses_next = dec_pulses;
        pulses_next.store = dec_pulses.store;
        wd_ack_next = dec_pulses.wd_ack;
        sample_next.current = I_BUS_CURRENT;
        sample_next.power = I_INPUT_POWER;
        rdata_next = motor_regs_pkg::RESET_WORD;
        rvalid_next = I_RD;
        if (I_RD && I_ADDR == motor_regs_pkg::PWR_STAT_OFS) begin
            rdata_next = sample_reg;
        end
        // command word reads zero, other offsets zero too
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESET_N) begin
            pulses_reg <= '0;
            wd_ack_reg <= 1'b0;
            sample_reg <= '0;
            rdata_reg <= motor_regs_pkg::RESET_WORD;
            rvalid_reg <= 1'b0;
        end else begin
            pulses_reg <= pulses_next;
            wd_ack_reg <= wd_ack_next;
            sample_reg <= sample_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign O_RDATA = rdata_reg;
    assign O_RVALID = rvalid_reg;
    assign O_NVM_STORE = pulses_reg.store;
    assign O_NVM_RECALL = pulses_reg.recall;
    assign O_FAULT_CLEAR = pulses_reg.fault_clear;
    assign O_RETRY_CLEAR = pulses_reg.retry_clear;
    assign O_STORE_REFUSED = pulses_reg.store_refused;
    assign O_HOST_WD_ACK = wd_ack_reg;

    // status sampled every cycle; the host sees data one cycle old
    store_key_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        O_NVM_STORE |-> $past(I_WDATA[motor_regs_pkg::KEY_HI:
        motor_regs_pkg::KEY_LO]) == UNLOCK_KEY)
        else $error("store accepted without key");
    store_cause_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_WR && I_ADDR == motor_regs_pkg::ALGO_CMD_OFS
         && I_WDATA[motor_regs_pkg::STORE_BIT]
         && I_WDATA[motor_regs_pkg::KEY_HI:motor_regs_pkg::KEY_LO]
            == UNLOCK_KEY) |=> O_NVM_STORE)
        else $error("store not issued");
    recall_cause_a: assert property (@(posedge I_MCLK)
        disable iff (!I_RESET_N)
        O_NVM_RECALL == $past(I_WR && I_ADDR == motor_regs_pkg::ALGO_CMD_OFS
        && I_WDATA[motor_regs_pkg::RECALL_BIT]))
        else $error("recall mismatch");
    fault_clr_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        O_FAULT_CLEAR |-> $past(algo_wr))
        else $error("fault clear without write");
    retry_clr_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (algo_wr && I_WDATA[motor_regs_pkg::RETRY_CLR_BIT]) |=> O_RETRY_CLEAR)
        else $error("retry clear missed");
    wd_selfclr_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (O_HOST_WD_ACK && !(algo_wr && I_WDATA[motor_regs_pkg::WD_ACK_BIT]))
        |=> !O_HOST_WD_ACK)
        else $error("ack did not self clear");
    status_read_a: assert property (@(posedge I_MCLK)
        disable iff (!I_RESET_N)
        (I_RD && I_ADDR == motor_regs_pkg::PWR_STAT_OFS)
        |=> O_RDATA[motor_regs_pkg::CURR_HI:
        motor_regs_pkg::CURR_LO] == $past(sample_reg.current))
        else $error("current readback wrong");
    power_read_a: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_RD && I_ADDR == motor_regs_pkg::PWR_STAT_OFS) |=>
        O_RDATA[motor_regs_pkg::POW_HI:motor_regs_pkg::POW_LO]
        == $past(sample_reg.power))
        else $error("power readback wrong");
    cmd_read_zero_a: assert property (@(posedge I_MCLK)
        disable iff (!I_RESET_N)
        (I_RD && I_ADDR != motor_regs_pkg::PWR_STAT_OFS) |=>
        O_RDATA == motor_regs_pkg::RESET_WORD ##1 1'b1)
        else $error("write-only word read nonzero");
endmodule : motor_ctrl_status_algo_regs

// *** motor_regs_pkg.sv ***
// Purpose: constants and carriers for the motor command/status registers
// Assumes: register offsets are byte addresses on the serial register port
// Notes: key value is a parameter default, value arbitrary
package motor_regs_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ALGO_CMD_OFS = 8'hE6;
    localparam logic [7:0] DEV_CMD_OFS = 8'hE8;
    localparam logic [7:0] PWR_STAT_OFS = 8'hEC;
    localparam int STORE_BIT = 31;
    localparam int RECALL_BIT = 30;
    localparam int FAULT_CLR_BIT = 29;
    localparam int RETRY_CLR_BIT = 28;
    localparam int KEY_HI = 27;
    localparam int KEY_LO = 20;
    localparam int WD_ACK_BIT = 0;
    localparam int CURR_HI = 31;
    localparam int CURR_LO = 16;
    localparam int POW_HI = 15;
    localparam int POW_LO = 0;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5A;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef struct packed {
        logic store;
        logic recall;
        logic fault_clear;
        logic retry_clear;
        logic wd_ack;
        logic store_refused;
    } cmd_pulses_t;

    typedef struct packed {
        logic [15:0] current;
        logic [15:0] power;
    } pwr_sample_t;
endpackage : motor_regs_pkg

// *** cmd_decode.sv ***
// Purpose: decode a write of the algorithm command word into pulses
// Assumes: one write strobe per accepted bus write
// Notes: purely combinational, registered by the caller
`timescale 1ns/10ps
module cmd_decode #(
    parameter logic [7:0] UNLOCK_KEY = motor_regs_pkg::UNLOCK_KEY_DEFAULT
) (
    input wire logic i_wr,
    input wire logic [31:0] i_data,
    output motor_regs_pkg::cmd_pulses_t o_pulses
);
    logic key_ok;
    always_comb begin
        key_ok = (i_data[motor_regs_pkg::KEY_HI:motor_regs_pkg::KEY_LO]
                  == UNLOCK_KEY);
        o_pulses.store = i_wr & i_data[motor_regs_pkg::STORE_BIT] & key_ok;
        o_pulses.store_refused = i_wr & i_data[motor_regs_pkg::STORE_BIT]
                                 & ~key_ok;
        o_pulses.recall = i_wr & i_data[motor_regs_pkg::RECALL_BIT];
        o_pulses.fault_clear = i_wr & i_data[motor_regs_pkg::FAULT_CLR_BIT];
        o_pulses.retry_clear = i_wr & i_data[motor_regs_pkg::RETRY_CLR_BIT];
        o_pulses.wd_ack = i_wr & i_data[motor_regs_pkg::WD_ACK_BIT];
    end
endmodule : cmd_decode

// *** host_model.sv ***
// Purpose: host side of the serial register port
// Assumes: one strobe cycle per access, answer one cycle later
// Notes: each access waits an idle cycle first, so strobes never retoggle
`timescale 1ns/10ps
module host_model (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk);
        #1;
        o_wr = 1'b0;
        // stale data must not look valid
        o_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge i_clk);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk);
        #1;
        q = i_rdata;
        o_rd = 1'b0;
    endtask : rd
endmodule : host_model

// *** motor_ctrl_status_algo_regs_tb.sv ***
// Purpose: self-checking bench for the command and status registers
// Assumes: outputs are looked at 1 ns after the edge that answers
// Notes: no watchdog of the motor itself is modelled
`timescale 1ns/10ps
module motor_ctrl_status_algo_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr, rd, rvalid, st, rc, fc, rt, rf, wd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [15:0] cur = 16'h0000;
    logic [15:0] pow = 16'h0000;
    int failures = 0;
    int n_checks = 0;
    logic [31:0] cmd [9] = '{32'h85A0_0000, 32'h8000_0000, 32'h4000_0000,
        32'h2000_0000, 32'h1000_0000, 32'h0000_0001, 32'h000F_FFFE,
        32'h05A0_0000, 32'hF5A0_0001};
    logic [5:0] want [9] = '{6'h20, 6'h02, 6'h10, 6'h08, 6'h04, 6'h01,
        6'h00, 6'h00, 6'h3D};
    always #50 clk = ~clk;
    motor_ctrl_status_algo_regs i_dut (.I_MCLK(clk), .I_RESET_N(rst_n),
        .I_WR(wr), .I_RD(rd), .I_ADDR(addr), .I_WDATA(wdata),
        .I_BUS_CURRENT(cur), .I_INPUT_POWER(pow), .O_RDATA(rdata),
        .O_RVALID(rvalid), .O_NVM_STORE(st), .O_NVM_RECALL(rc),
        .O_FAULT_CLEAR(fc), .O_RETRY_CLEAR(rt), .O_STORE_REFUSED(rf),
        .O_HOST_WD_ACK(wd));
    host_model i_host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
        .o_addr(addr), .o_wdata(wdata));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    function automatic logic [31:0] pulses();
        return {26'h0, st, rc, fc, rt, rf, wd};
    endfunction : pulses
    task automatic stat_read(input logic [31:0] exp);
        i_host.rd(motor_regs_pkg::PWR_STAT_OFS, q);
        check("status word", q, exp);
        check("read valid", {31'h0, rvalid}, 32'h1);
    endtask : stat_read
    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        stat_read(32'h0);
        cur = 16'h1234;
        pow = 16'hABCD;
        stat_read(32'h1234_ABCD);
        cur = 16'hFFFF;
        pow = 16'h0000;
        stat_read(32'hFFFF_0000);
        i_host.rd(motor_regs_pkg::ALGO_CMD_OFS, q);
        check("command read", q, 32'h0);
        foreach (cmd[i]) begin
            i_host.wr(motor_regs_pkg::ALGO_CMD_OFS, cmd[i]);
            check("command pulses", pulses(), {26'h0, want[i]});
            @(posedge clk);
            #1;
            check("pulses clear", pulses(), 32'h0);
        end
        // command bits at other offsets must not fire
        i_host.wr(motor_regs_pkg::DEV_CMD_OFS, 32'hF5A0_0001);
        check("other offset", pulses(), 32'h0);
        i_host.wr(motor_regs_pkg::PWR_STAT_OFS, 32'hF5A0_0001);
        check("status write", pulses(), 32'h0);
        stat_read(32'hFFFF_0000);
        print_verdict();
    end
    initial begin
        #20000;
        failures++;
        print_verdict();
    end
endmodule : motor_ctrl_status_algo_regs_tb
